//--- ssr_sanitize_status_reporter.sv
// sanitize status query handling and sanitize device state tracking
// Operation
// RULE1: opcode B4h with feature 0000h selects the status query
// RULE2: the status query is served in every sanitize state
// RULE3: clear-failed, failure mode set and failed operation return machine to idle
// RULE4: clear-failed with failure mode clear aborts the query
// RULE5: count bit 15 set on success, cleared on entering running state
// RULE6: completion flag kept outside reset, reloaded from stored copy
// RULE7: count bit 14 reports a sanitize in progress
// RULE8: count bit 13 reports the frozen state
// RULE9: progress high byte on cylinder low, low byte on sector number
// RULE10: progress reads all ones outside the running state
// RULE11: progress is numerator over 65536, rising as sanitize advances
// RULE12: abort error when completed sanitize left sectors unsanitized
// RULE13: error reason code on sector number from the listed codes
// RULE14: frozen state returns to idle on power-on or hardware reset
// RULE15: clear-failed outside failed state is ignored, status returned
// RULE16: reserved reason codes never returned, unlisted gives code 00h
`timescale 1ns/1ps
`default_nettype none
module ssr_sanitize_status_reporter
  import ssr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  // command block from the host
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_opcode,
  input wire logic [15:0] i_cmd_feature,
  input wire logic [15:0] i_cmd_count,
  // events from the sanitize engine
  input wire logic i_san_start,
  input wire logic i_san_fail_mode,
  input wire logic i_san_progress_valid,
  input wire logic [15:0] i_san_progress,
  input wire logic i_san_done,
  input wire logic i_san_ok,
  input wire logic i_san_freeze,
  input wire logic i_nv_done,
  // answer to the host
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_error,
  output logic [7:0] o_rsp_status,
  output logic [15:0] o_rsp_count,
  output logic [7:0] o_rsp_sector_number,
  output logic [7:0] o_rsp_cylinder_low,
  output logic o_nv_done,
  output logic [2:0] o_sd_state
);
  ssr_sd_state_t state_q, state_d;
  logic fail_mode_q;
  logic fail_mode_d;
  logic unsanitized_q;
  logic unsanitized_d;
  logic [15:0] progress_q;
  logic [15:0] progress_d;
  logic done_q;
  logic done_d;
  logic load_q;
  logic rsp_valid_q;
  logic [7:0] rsp_error_q;
  logic [7:0] rsp_error_d;
  logic [7:0] rsp_status_q;
  logic [7:0] rsp_status_d;
  logic [15:0] rsp_count_q;
  logic [15:0] rsp_count_d;
  logic [7:0] rsp_sn_q;
  logic [7:0] rsp_sn_d;
  logic [7:0] rsp_cl_q;
  logic [7:0] rsp_cl_d;

  // error byte: only the abort bit is ever raised by this block
  function automatic logic [7:0] f_error(input logic abort);
    logic [7:0] e;
    e = 8'h00;
    e[SSR_ERR_ABORT_BIT] = abort;
    f_error = e;
  endfunction

  // status byte: ready and seek complete stand, error follows a refusal
  function automatic logic [7:0] f_status(input logic err);
    logic [7:0] s;
    s = 8'h00;
    s[SSR_STS_RDY_BIT] = 1'b1;
    s[SSR_STS_DSC_BIT] = 1'b1;
    s[SSR_STS_ERR_BIT] = err;
    f_status = s;
  endfunction

  // RULE13: RULE16: listed codes only
  function automatic logic [7:0] f_reason(input logic bad_feature, input logic unsanitized);
    logic [7:0] r;
    r = SSR_RSN_NONE;
    if (bad_feature) begin
      r = SSR_RSN_BAD_FEATURE;
    end else if (unsanitized) begin
      r = SSR_RSN_UNSUCCESSFUL;
    end
    f_reason = r;
  endfunction

  // state tests shared by the decode, the flags and the progress path
  wire in_frozen = (state_q == SSR_SD_FROZEN);
  wire in_running = (state_q == SSR_SD_RUNNING);
  wire in_failed = (state_q == SSR_SD_FAILED);
  // a start counts only where the machine really enters running, so an
  // ignored start in frozen or failed cannot disturb the bookkeeping
  wire start_taken = (state_d == SSR_SD_RUNNING) && !in_running;
  wire finish_ok = in_running && i_san_done && i_san_ok;
  wire finish_bad = in_running && i_san_done && !i_san_ok;

  // RULE1: status query decode
  wire is_status = i_cmd_valid && (i_cmd_opcode == SSR_CMD_OPCODE)
                   && (i_cmd_feature == SSR_FEAT_STATUS);
  // any other opcode or feature is refused as an invalid feature value
  wire refuse_feature = i_cmd_valid && !is_status;
  // RULE15: clear outside failed ignored
  wire clear_req = is_status && i_cmd_count[SSR_CNT_CLEAR_BIT] && in_failed;
  // RULE4: abort without failure mode
  wire abort_clear = clear_req && !fail_mode_q;
  // RULE3: failed back to idle
  wire do_clear = clear_req && fail_mode_q;
  // RULE12: abort on unsanitized sectors
  wire abort_unsan = is_status && in_failed && unsanitized_q && !do_clear;
  wire do_abort = abort_clear || abort_unsan;
  wire rsp_err = refuse_feature || do_abort;
  wire [7:0] reason = f_reason(refuse_feature, abort_unsan);

  // RULE10: all ones outside running
  wire [15:0] progress_out = in_running ? progress_q : SSR_PROGRESS_IDLE;

  // RULE5: RULE7: RULE8: flag bit placement
  wire [15:0] count_out;
  for (genvar b = 0; b < 16; b++) begin : g_count
    if (b == SSR_CNT_DONE_BIT) begin : g_done
      assign count_out[b] = done_q;
    end else if (b == SSR_CNT_BUSY_BIT) begin : g_busy
      assign count_out[b] = in_running;
    end else if (b == SSR_CNT_FROZEN_BIT) begin : g_frozen
      assign count_out[b] = in_frozen;
    end else begin : g_zero
      assign count_out[b] = 1'b0;
    end
  end

  // state moves; RULE2: the query never blocks any state
  always_comb begin
    state_d = state_q;
    case (state_q)
      SSR_SD_IDLE, SSR_SD_SUCCEEDED: begin
        if (i_san_freeze) begin
          state_d = SSR_SD_FROZEN;
        end else if (i_san_start) begin
          state_d = SSR_SD_RUNNING;
        end
      end
      SSR_SD_FROZEN: begin
        state_d = SSR_SD_FROZEN;
      end
      SSR_SD_RUNNING: begin
        if (i_san_done) begin
          state_d = i_san_ok ? SSR_SD_SUCCEEDED : SSR_SD_FAILED;
        end
      end
      SSR_SD_FAILED: begin
        // RULE15: clear outside failed never reaches here
        if (do_clear) begin
          state_d = SSR_SD_IDLE;
        end else if (i_san_start && fail_mode_q) begin
          state_d = SSR_SD_RUNNING;
        end
      end
      default: begin
        state_d = SSR_SD_IDLE;
      end
    endcase
  end

  // RULE14: any reset leaves frozen for idle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= SSR_SD_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // next values: a set wins over a clear wherever both could meet
  assign fail_mode_d = start_taken ? i_san_fail_mode : fail_mode_q;
  assign unsanitized_d = finish_bad
                         || (unsanitized_q && !start_taken && !finish_ok && !do_clear);

  // RULE11: numerator over 65536
  // engine updates may be sparse, so the last value holds between them
  assign progress_d = !in_running ? 16'h0000
                      : (i_san_progress_valid ? i_san_progress : progress_q);

  // RULE5: RULE6: success, start, stored copy
  // a start in the reload cycle must still clear, hence reload comes last
  assign done_d = finish_ok ? 1'b1
                  : (start_taken ? 1'b0 : (load_q ? i_nv_done : done_q));

  // RULE2: RULE9: answer in every state
  assign rsp_error_d = f_error(rsp_err);
  assign rsp_status_d = f_status(rsp_err);
  assign rsp_count_d = count_out;
  assign rsp_sn_d = rsp_err ? reason : progress_out[7:0];
  assign rsp_cl_d = refuse_feature ? 8'h00 : progress_out[15:8];

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      fail_mode_q <= 1'b0;
    end else begin
      fail_mode_q <= fail_mode_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      unsanitized_q <= 1'b0;
    end else begin
      unsanitized_q <= unsanitized_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      progress_q <= 16'h0000;
    end else begin
      progress_q <= progress_d;
    end
  end

  // RULE6: reload stored flag
  // the flag lives outside this block; reset clears the local copy and arms the one-cycle reload
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      load_q <= 1'b1;
    end else begin
      load_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  // answer strobe follows every taken command by one cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= i_cmd_valid;
    end
  end

  // answer bytes hold until the next command replaces them
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rsp_error_q <= 8'h00;
    end else if (i_cmd_valid) begin
      rsp_error_q <= rsp_error_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rsp_status_q <= 8'h00;
    end else if (i_cmd_valid) begin
      rsp_status_q <= rsp_status_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rsp_count_q <= 16'h0000;
    end else if (i_cmd_valid) begin
      rsp_count_q <= rsp_count_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rsp_sn_q <= 8'h00;
    end else if (i_cmd_valid) begin
      rsp_sn_q <= rsp_sn_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rsp_cl_q <= 8'h00;
    end else if (i_cmd_valid) begin
      rsp_cl_q <= rsp_cl_d;
    end
  end

  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp_error = rsp_error_q;
  assign o_rsp_status = rsp_status_q;
  assign o_rsp_count = rsp_count_q;
  assign o_rsp_sector_number = rsp_sn_q;
  assign o_rsp_cylinder_low = rsp_cl_q;
  assign o_nv_done = done_q;
  assign o_sd_state = state_q;
endmodule
`default_nettype wire

//--- ssr_pkg.sv
// constants for the sanitize status reporter
package ssr_pkg;
  localparam logic [7:0] SSR_CMD_OPCODE = 8'hB4;
  localparam logic [15:0] SSR_FEAT_STATUS = 16'h0000;
  localparam int SSR_CNT_CLEAR_BIT = 0;
  localparam int SSR_CNT_DONE_BIT = 15;
  localparam int SSR_CNT_BUSY_BIT = 14;
  localparam int SSR_CNT_FROZEN_BIT = 13;
  localparam logic [15:0] SSR_PROGRESS_IDLE = 16'hFFFF;
  localparam logic [7:0] SSR_RSN_NONE = 8'h00;
  localparam logic [7:0] SSR_RSN_UNSUCCESSFUL = 8'h01;
  localparam logic [7:0] SSR_RSN_BAD_FEATURE = 8'h02;
  localparam logic [7:0] SSR_RSN_FROZEN = 8'h03;
  localparam int SSR_ERR_ABORT_BIT = 2;
  localparam int SSR_STS_ERR_BIT = 0;
  localparam int SSR_STS_DSC_BIT = 4;
  localparam int SSR_STS_RDY_BIT = 6;
  localparam logic [7:0] SSR_STATUS_OK = 8'h50;
  typedef enum logic [2:0] {
    SSR_SD_IDLE = 3'h0,
    SSR_SD_FROZEN = 3'h1,
    SSR_SD_RUNNING = 3'h2,
    SSR_SD_FAILED = 3'h3,
    SSR_SD_SUCCEEDED = 3'h4
  } ssr_sd_state_t;
endpackage

//--- ssr_chk.sv
// assertion checker for the sanitize status reporter
`timescale 1ns/1ps
`default_nettype none
module ssr_chk
  import ssr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_opcode,
  input wire logic [15:0] i_cmd_feature,
  input wire logic o_rsp_valid,
  input wire logic [7:0] o_rsp_error,
  input wire logic [7:0] o_rsp_status,
  input wire logic [15:0] o_rsp_count,
  input wire logic [7:0] o_rsp_sector_number,
  input wire logic [7:0] o_rsp_cylinder_low,
  input wire logic [2:0] o_sd_state
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire good = i_cmd_valid && i_cmd_opcode == SSR_CMD_OPCODE && i_cmd_feature == SSR_FEAT_STATUS;
  wire err = o_rsp_status[SSR_STS_ERR_BIT];
  property p_ans; i_cmd_valid |=> o_rsp_valid; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !i_cmd_valid |=> !o_rsp_valid; endproperty
  a_one: assert property (p_one) else $error("stray answer");
  property p_bad; i_cmd_valid && !good |=> err
    && o_rsp_sector_number == SSR_RSN_BAD_FEATURE; endproperty
  a_bad: assert property (p_bad) else $error("bad feature not refused");
  property p_idle; good && o_sd_state != SSR_SD_RUNNING |=> err || {o_rsp_cylinder_low,
    o_rsp_sector_number} == SSR_PROGRESS_IDLE; endproperty
  a_idle: assert property (p_idle) else $error("progress not all ones");
  property p_frz; good && o_sd_state == SSR_SD_FROZEN |=> o_rsp_count[SSR_CNT_FROZEN_BIT];
    endproperty
  a_frz: assert property (p_frz) else $error("frozen flag");
  property p_run; good && o_sd_state == SSR_SD_RUNNING |=> o_rsp_count[15:14] == 2'h1; endproperty
  a_run: assert property (p_run) else $error("running flags");
  property p_abt; o_rsp_valid && err |-> o_rsp_error[SSR_ERR_ABORT_BIT]; endproperty
  a_abt: assert property (p_abt) else $error("error without abort");
  property p_rsv; o_rsp_valid && err |-> o_rsp_sector_number <= SSR_RSN_FROZEN; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved reason");
  c_fail: cover property (good && o_sd_state == SSR_SD_FAILED);
  c_run: cover property (good && o_sd_state == SSR_SD_RUNNING);
  c_frz: cover property (good && o_sd_state == SSR_SD_FROZEN);
endmodule
bind ssr_sanitize_status_reporter ssr_chk i_ssr_chk (.*);
`default_nettype wire

//--- ssr_host.sv
// host model issuing command blocks
`timescale 1ns/1ps
`default_nettype none
module ssr_host (
  input wire logic i_clock,
  output logic o_valid,
  output logic [7:0] o_op,
  output logic [15:0] o_feat,
  output logic [15:0] o_cnt
);
  initial {o_valid, o_op, o_feat, o_cnt} = '0;
  task automatic send(input logic [7:0] op, input logic [15:0] f, input logic [15:0] c);
    @(negedge i_clock);
    {o_valid, o_op, o_feat, o_cnt} = {1'b1, op, f, c};
    @(negedge i_clock);
    // released fields turn over so a stale copy is never mistaken for a live one
    {o_valid, o_op, o_feat, o_cnt} = {1'b0, ~op, ~f, ~c};
  endtask
endmodule
`default_nettype wire

//--- ssr_sanitize_status_reporter_tb.sv
// self-checking bench for the sanitize status reporter
`timescale 1ns/1ps
`default_nettype none
module ssr_sanitize_status_reporter_tb
  import ssr_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cv, st, fm, pv, dn, ok, fz, nv, rv, nvo;
  logic [7:0] op, er, ss, sn, cl;
  logic [15:0] ft, ct, pg, rc;
  logic [2:0] sd;
  int n_errors = 0;
  int n_compared = 0;
  always #2.5 clk = ~clk;
  ssr_host i_ssr_host (.i_clock(clk), .o_valid(cv), .o_op(op), .o_feat(ft), .o_cnt(ct));
  ssr_sanitize_status_reporter i_ssr_sanitize_status_reporter (.i_clock(clk), .i_rst(rst),
    .i_cmd_valid(cv), .i_cmd_opcode(op), .i_cmd_feature(ft), .i_cmd_count(ct), .i_san_start(st),
    .i_san_fail_mode(fm), .i_san_progress_valid(pv), .i_san_progress(pg), .i_san_done(dn),
    .i_san_ok(ok), .i_san_freeze(fz), .i_nv_done(nv), .o_rsp_valid(rv), .o_rsp_error(er),
    .o_rsp_status(ss), .o_rsp_count(rc), .o_rsp_sector_number(sn), .o_rsp_cylinder_low(cl),
    .o_nv_done(nvo), .o_sd_state(sd));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // engine events packed as start, fail mode, progress, done, ok, freeze
  task ev(input logic [5:0] p, input logic [15:0] g);
    @(negedge clk);
    {st, fm, pv, dn, ok, fz, pg} = {p, g};
    @(negedge clk);
    {st, pv, dn, fz} = 4'h0;
  endtask
  task q(input logic [7:0] o, input logic [15:0] f, input logic [15:0] c);
    i_ssr_host.send(o, f, c);
    chk(rv, 1'h1);
  endtask
  task reset_dut;
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
  endtask
  task t_cmd;
    q(8'hB4, 16'h0000, 16'h0000);
    chk({cl, sn}, SSR_PROGRESS_IDLE);
    q(8'hB4, 16'h0001, 16'h0000);
    chk({er, ss}, 16'h0451);
    q(8'hB5, 16'h0000, 16'h0000);
    chk(sn, SSR_RSN_BAD_FEATURE);
    $display("command decode done");
  endtask
  task t_run;
    ev(6'h30, 16'h0000);
    q(8'hB4, 16'h0000, 16'h0000);
    chk(rc, 16'h4000);
    ev(6'h08, 16'h1234);
    q(8'hB4, 16'h0000, 16'h0000);
    chk({cl, sn}, 16'h1234);
    ev(6'h06, 16'h0000);
    q(8'hB4, 16'h0000, 16'h0000);
    chk({rc, nvo}, 17'h10001);
    $display("running and success done");
  endtask
  task t_fail;
    ev(6'h30, 16'h0000);
    ev(6'h04, 16'h0000);
    q(8'hB4, 16'h0000, 16'h0000);
    chk({er, sn}, 16'h0401);
    q(8'hB4, 16'h0000, 16'h0001);
    chk(sd, SSR_SD_IDLE);
    ev(6'h20, 16'h0000);
    ev(6'h04, 16'h0000);
    q(8'hB4, 16'h0000, 16'h0001);
    chk({er, sn, 5'h00, sd}, {16'h0401, 8'h03});
    $display("failure handling done");
  endtask
  task t_frz;
    nv = 1'b1;
    reset_dut();
    ev(6'h01, 16'h0000);
    q(8'hB4, 16'h0000, 16'h0001);
    chk({ss, 5'h00, sd}, {SSR_STATUS_OK, 8'h01});
    chk(rc, 16'hA000);
    reset_dut();
    chk(sd, SSR_SD_IDLE);
    $display("freeze and reset done");
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  initial begin
    {st, fm, pv, dn, ok, fz, nv, pg} = '0;
    reset_dut();
    t_cmd();
    t_run();
    t_fail();
    t_frz();
    complete_run();
  end
endmodule
`default_nettype wire
